// ### periph_irq_flags_reset_cause_test.sv
// Self-checking bench for the interrupt flag and reset cause registers.
// Assumes the register port answers reads in the cycle after the strobe.
`timescale 1ns/1ps
module periph_irq_flags_reset_cause_test;
	logic clk, rst, wr, rd, mode, por, bor, bod, t1p, irq;
	logic [7:0] addr, wdata, rdata, ev, pulse;
	logic [15:0] t1c;
	int bad_count, n_tests, cyc;
	pifr_periph i_per (.clk(clk), .rst(rst), .ev(ev), .t1_preset(t1p), .pulse(pulse),
		.timer1_count(t1c));
	pifr_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .conv_done(pulse[0]), .serial_done(pulse[1]), .capture_event(pulse[2]),
		.compare_match(pulse[3]), .ccp_compare_mode(mode), .timer2_match(pulse[4]),
		.timer1_count(t1c), .timer0_overflow(pulse[5]), .ext_pin_event(pulse[6]),
		.port_change_event(pulse[7]), .power_on_reset(por), .brownout_reset(bor),
		.brownout_detect_enable(bod), .irq_request(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data only stand in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", exp, rdata);
	endtask
	task automatic fire(input logic [7:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
	endtask
	task automatic roll_t1;
		@(posedge clk);
		t1p <= 1'b1;
		@(posedge clk);
		t1p <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(8'h0C, 8'h00);
		rd_chk(8'h8C, 8'h00);
		rd_chk(8'h8E, 8'h00);
		rd_chk(8'h55, 8'h00);
		wr_reg(8'h8B, 8'hC0);
		wr_reg(8'h8E, 8'h03);
		rd_chk(8'h0B, 8'hC0);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h8B, 8'h00);
		rd_chk(8'h8E, 8'h03);
		$display("done reset");
	endtask
	task automatic t_flags;
		@(posedge clk);
		mode <= 1'b1;
		fire(8'h04);
		rd_chk(8'h0C, 8'h00);
		fire(8'h08);
		rd_chk(8'h0C, 8'h04);
		@(posedge clk);
		mode <= 1'b0;
		wr_reg(8'h0C, 8'h00);
		fire(8'h17);
		roll_t1();
		rd_chk(8'h0C, 8'h4F);
		repeat (20) @(posedge clk);
		rd_chk(8'h0C, 8'h4F);
		wr_reg(8'h0C, 8'h00);
		rd_chk(8'h0C, 8'h00);
		wr_reg(8'h0C, 8'hFF);
		rd_chk(8'h0C, 8'h4F);
		wr_reg(8'h0C, 8'h00);
		fire(8'hE0);
		rd_chk(8'h8B, 8'h07);
		wr_reg(8'h8B, 8'h00);
		$display("done flags");
	endtask
	task automatic t_irq;
		wr_reg(8'h0C, 8'h00);
		wr_reg(8'h8C, 8'h01);
		wr_reg(8'h8B, 8'hC0);
		repeat (3) @(posedge clk);
		#1 chk("irq", 8'h00, {7'h00, irq});
		roll_t1();
		#1 chk("irq", 8'h01, {7'h00, irq});
		wr_reg(8'h8B, 8'h40);
		repeat (2) @(posedge clk);
		#1 chk("irq", 8'h00, {7'h00, irq});
		wr_reg(8'h8C, 8'hFF);
		rd_chk(8'h8C, 8'h4F);
		wr_reg(8'h8C, 8'h00);
		wr_reg(8'h8B, 8'h00);
		$display("done irq");
	endtask
	task automatic t_race;
		wr_reg(8'h0C, 8'h00);
		@(posedge clk);
		wr <= 1'b1;
		addr <= 8'h0C;
		wdata <= 8'h00;
		ev <= 8'h11;
		@(posedge clk);
		wr <= 1'b0;
		ev <= 8'h00;
		rd_chk(8'h0C, 8'h42);
		$display("done race");
	endtask
	task automatic t_cause;
		wr_reg(8'h8E, 8'h03);
		rd_chk(8'h8E, 8'h03);
		@(posedge clk);
		bor <= 1'b1;
		@(posedge clk);
		bor <= 1'b0;
		rd_chk(8'h8E, 8'h02);
		@(posedge clk);
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rd_chk(8'h8E, 8'h00);
		@(posedge clk);
		bod <= 1'b0;
		wr_reg(8'h8E, 8'h03);
		repeat (4) @(posedge clk);
		@(posedge clk);
		bor <= 1'b1;
		@(posedge clk);
		bor <= 1'b0;
		rd_chk(8'h8E, 8'h03);
		@(posedge clk);
		bod <= 1'b1;
		$display("done cause");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Clock and hang guard; the whole run needs well under 1000 cycles
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		// Reset and power-on start together
		{rst, wr, rd, mode, por, bor, t1p} = 7'h44;
		bod = 1'b1;
		{addr, wdata, ev} = 24'h000000;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		por <= 1'b0;
		t_reset();
		t_flags();
		t_irq();
		t_race();
		t_cause();
		test_done();
	end
endmodule

// ### pifr_periph.sv
// Peripheral stand-in: turns bench requests into event pulses and runs timer 1.
// Assumes requests arrive as one-cycle pulses on the block's own clock.
`timescale 1ns/1ps
module pifr_periph (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] ev,
	input wire logic t1_preset,
	output logic [7:0] pulse,
	output logic [15:0] timer1_count
);
	// Events pass straight through so a test can align one with a register write
	assign pulse = ev;
	// Free-running timer; the preset reaches rollover without 65536 idle cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer1_count <= 16'h0000;
		end else if (t1_preset) begin
			timer1_count <= 16'hFFFD;
		end else begin
			timer1_count <= timer1_count + 16'h0001;
		end
	end
endmodule

// ### pifr_pkg.sv
// Package for the peripheral interrupt flag and reset cause block.
// Assumes an 8-bit register port with word addresses as printed.
package pifr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h8B;
	localparam logic [7:0] ADDR_CTRL_LO = 8'h0B;
	localparam logic [7:0] ADDR_ENABLES = 8'h8C;
	localparam logic [7:0] ADDR_CAUSE = 8'h8E;
	// Implemented peripheral flag and enable bits
	localparam logic [7:0] PERIPH_MASK = 8'h4F;
	localparam logic [7:0] CAUSE_MASK = 8'h03;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Peripheral bit positions
	localparam int unsigned BIT_TIMER1 = 0;
	localparam int unsigned BIT_TIMER2 = 1;
	localparam int unsigned BIT_CCP = 2;
	localparam int unsigned BIT_SERIAL = 3;
	localparam int unsigned BIT_CONV = 6;
	// Control register bit positions
	localparam int unsigned BIT_GIE = 7;
	localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int unsigned BIT_TIMER0_IRQ_ENABLE = 5;
	localparam int unsigned BIT_EXTIE = 4;
	localparam int unsigned BIT_PORTIE = 3;
	localparam int unsigned BIT_T0F = 2;
	localparam int unsigned BIT_EXTF = 1;
	localparam int unsigned BIT_PORTF = 0;
	// Cause register bit positions
	localparam int unsigned BIT_POWERON = 1;
	localparam int unsigned BIT_BROWNOUT = 0;
	localparam logic [15:0] TIMER1_MAX = 16'hFFFF;
endpackage

// ### pifr_sync.sv
// Three-stage synchroniser for one pin-level input.
// Assumes the level may change at any time relative to clk.
`timescale 1ns/1ps
module pifr_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;

	// Shift chain; a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Hold output until the two late stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else if (s2 == s3) begin
			q <= s3;
		end
	end
endmodule

// ### pifr_top.sv
// Peripheral interrupt flags, enables, control and reset cause registers.
// Assumes peripheral event inputs are same-clock pulses; pin straps are synchronised.
//
// Contract
// R1: Each peripheral flag sets on its event regardless of its enable and the global enable.
// R2: Software should clear a flag before setting its enable to avoid a stale request.
// R3: The flag register has read-write bits 6,3,2,1,0 reset to zero; bits 7,5,4 read zero.
// R4: The conversion-done flag sets on conversion completion and only software clears it.
// R5: The timer-2 match flag sets on period match and stays set until software clears it.
// R6: The enable register at 8Ch has mask bits 6,3,2,1,0, reset to zero.
// R7: The control register holds global, peripheral, three enables and three flags, reads in both banks.
// R8: The cause register bit 1 tells a power-on reset from a pin or watchdog reset.
// R9: The cause register bit 0 flags a brown-out reset on devices with brown-out detection.
// R10: The brown-out flag is undefined after power-on, software sets it, and clear means brown-out.
// R11: With brown-out detection disabled the brown-out flag need not be predictable.
// R12: The timer-1 flag sets when the 16-bit timer rolls over from FFFFh to 0000h.
// R13: With global enable set, any flagged and masked source raises a request at once; here the request is registered and rises one clock later.
// R14: Any reset clears the global interrupt enable.
// R15: The capture-compare flag sets on capture in capture mode or match in compare mode.
// R16: A hardware set wins over a same-cycle software write to a flag.
`timescale 1ns/1ps
module pifr_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic conv_done,
	input wire logic serial_done,
	input wire logic capture_event,
	input wire logic compare_match,
	input wire logic ccp_compare_mode,
	input wire logic timer2_match,
	input wire logic [15:0] timer1_count,
	input wire logic timer0_overflow,
	input wire logic ext_pin_event,
	input wire logic port_change_event,
	input wire logic power_on_reset,
	input wire logic brownout_reset,
	input wire logic brownout_detect_enable,
	output logic irq_request
);
	logic [7:0] flags;
	logic [7:0] enables;
	logic [7:0] ctrl;
	logic [1:0] cause;
	logic [15:0] timer1_prev;
	logic por_seen;
	logic bor_seen;
	logic bod_en_s;
	logic [7:0] periph_set;
	logic [7:0] ctrl_set;
	logic t1_roll;

	// Decode a register access for one address
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin-level inputs pass the synchroniser
	pifr_sync u_bod_sync (
		.clk(clk),
		.rst(rst),
		.d(brownout_detect_enable),
		.q(bod_en_s)
	);

	////////////////////////////////////////////////////////////////////
	// Timer-1 rollover detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer1_prev <= 16'h0000;
		end else begin
			timer1_prev <= timer1_count;
		end
	end

	assign t1_roll = (timer1_prev == pifr_pkg::TIMER1_MAX) && (timer1_count == 16'h0000); // R12

	// Hardware set terms, independent of any enable
	always_comb begin
		periph_set = pifr_pkg::ZERO_BYTE; // R1
		periph_set[pifr_pkg::BIT_CONV] = conv_done; // R4
		periph_set[pifr_pkg::BIT_SERIAL] = serial_done;
		periph_set[pifr_pkg::BIT_CCP] = ccp_compare_mode ? compare_match : capture_event; // R15
		periph_set[pifr_pkg::BIT_TIMER2] = timer2_match; // R5
		periph_set[pifr_pkg::BIT_TIMER1] = t1_roll; // R12
		ctrl_set = pifr_pkg::ZERO_BYTE;
		ctrl_set[pifr_pkg::BIT_T0F] = timer0_overflow;
		ctrl_set[pifr_pkg::BIT_EXTF] = ext_pin_event;
		ctrl_set[pifr_pkg::BIT_PORTF] = port_change_event;
	end

	////////////////////////////////////////////////////////////////////
	// Peripheral flags; set ORed after write so the event wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags <= pifr_pkg::FLAGS_RESET; // R3
		end else if (wr && hit(addr, pifr_pkg::ADDR_FLAGS)) begin
			flags <= (wdata | periph_set) & pifr_pkg::PERIPH_MASK; // R16
		end else begin
			flags <= flags | (periph_set & pifr_pkg::PERIPH_MASK); // R4 R5
		end
	end

	// Peripheral enable mask
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enables <= pifr_pkg::ENABLES_RESET;
		end else if (wr && hit(addr, pifr_pkg::ADDR_ENABLES)) begin
			enables <= wdata & pifr_pkg::PERIPH_MASK; // R6
		end
	end

	// Control register, reachable at both bank addresses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= pifr_pkg::CTRL_RESET; // R14
		end else if (wr && (hit(addr, pifr_pkg::ADDR_CTRL) || hit(addr, pifr_pkg::ADDR_CTRL_LO))) begin
			ctrl <= wdata | ctrl_set; // R7 R16
		end else begin
			ctrl <= ctrl | ctrl_set;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reset cause capture; reset inputs are sampled after release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			por_seen <= 1'b0;
			bor_seen <= 1'b0;
		end else begin
			por_seen <= power_on_reset;
			bor_seen <= brownout_reset && bod_en_s; // R11
		end
	end

	// Power-on clears both bits and brown-out clears bit 0; software sets them
	// No rst here: a pin or watchdog reset must leave the power-on record intact
	// Unknown until the first power-on pulse, like the undefined power-up value
	always_ff @(posedge clk) begin
		if (por_seen) begin
			cause <= 2'b00; // R8 R10
		end else if (bor_seen) begin
			cause[pifr_pkg::BIT_BROWNOUT] <= 1'b0; // R9 R10
		end else if (wr && hit(addr, pifr_pkg::ADDR_CAUSE)) begin
			cause <= wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data registered one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= pifr_pkg::ZERO_BYTE;
		end else if (rd) begin
			if (hit(addr, pifr_pkg::ADDR_FLAGS)) begin
				rdata <= flags; // R3
			end else if (hit(addr, pifr_pkg::ADDR_ENABLES)) begin
				rdata <= enables;
			end else if (hit(addr, pifr_pkg::ADDR_CTRL) || hit(addr, pifr_pkg::ADDR_CTRL_LO)) begin
				rdata <= ctrl;
			end else if (hit(addr, pifr_pkg::ADDR_CAUSE)) begin
				rdata <= {6'b000000, cause};
			end else begin
				rdata <= pifr_pkg::ZERO_BYTE;
			end
		end else begin
			rdata <= pifr_pkg::ZERO_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Request: registered so the output comes from a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= ctrl[pifr_pkg::BIT_GIE] && // R13
				((ctrl[pifr_pkg::BIT_PERIPHERAL_IRQ_ENABLE] && |(flags & enables)) ||
				(ctrl[pifr_pkg::BIT_TIMER0_IRQ_ENABLE] && ctrl[pifr_pkg::BIT_T0F]) ||
				(ctrl[pifr_pkg::BIT_EXTIE] && ctrl[pifr_pkg::BIT_EXTF]) ||
				(ctrl[pifr_pkg::BIT_PORTIE] && ctrl[pifr_pkg::BIT_PORTF]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_flag_write;
		wr && hit(addr, pifr_pkg::ADDR_FLAGS);
	endsequence

	// Named steps for the checks below
	sequence s_enable_write;
		wr && hit(addr, pifr_pkg::ADDR_ENABLES);
	endsequence

	sequence s_ctrl_write;
		wr && (hit(addr, pifr_pkg::ADDR_CTRL) || hit(addr, pifr_pkg::ADDR_CTRL_LO));
	endsequence

	sequence s_cause_write;
		wr && hit(addr, pifr_pkg::ADDR_CAUSE) && !por_seen && !bor_seen;
	endsequence

	sequence s_flags_read;
		rd && hit(addr, pifr_pkg::ADDR_FLAGS);
	endsequence

	a_event_sets_flag: assert property (@(posedge clk) disable iff (rst) // R1
		conv_done |=> flags[pifr_pkg::BIT_CONV])
		else $error("conversion flag not set");
	a_set_beats_write: assert property (@(posedge clk) disable iff (rst) // R16
		(s_flag_write and timer2_match) |=> flags[pifr_pkg::BIT_TIMER2])
		else $error("event lost to write");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // R5
		(flags[pifr_pkg::BIT_TIMER2] && !(wr && hit(addr, pifr_pkg::ADDR_FLAGS)))
		|=> flags[pifr_pkg::BIT_TIMER2])
		else $error("flag cleared by hardware");
	a_unused_zero: assert property (@(posedge clk) disable iff (rst) // R3
		(flags & ~pifr_pkg::PERIPH_MASK) == pifr_pkg::ZERO_BYTE)
		else $error("unimplemented flag bit set");
	a_mask_bits: assert property (@(posedge clk) disable iff (rst) // R6
		(enables & ~pifr_pkg::PERIPH_MASK) == pifr_pkg::ZERO_BYTE)
		else $error("unimplemented enable bit set");
	a_roll_flag: assert property (@(posedge clk) disable iff (rst) // R12
		t1_roll |=> flags[pifr_pkg::BIT_TIMER1])
		else $error("timer1 rollover not flagged");
	a_ccp_mode: assert property (@(posedge clk) disable iff (rst) // R15
		(ccp_compare_mode && compare_match) |=> flags[pifr_pkg::BIT_CCP])
		else $error("compare match not flagged");
	a_irq_raise: assert property (@(posedge clk) disable iff (rst) // R13
		(ctrl[pifr_pkg::BIT_GIE] && ctrl[pifr_pkg::BIT_PERIPHERAL_IRQ_ENABLE] && |(flags & enables))
		|=> irq_request)
		else $error("request not raised");
	a_gie_gate: assert property (@(posedge clk) disable iff (rst) // R13
		!ctrl[pifr_pkg::BIT_GIE] |=> !irq_request)
		else $error("request without global enable");
	a_por_cause: assert property (@(posedge clk) disable iff (rst) // R8
		por_seen |=> cause == 2'b00)
		else $error("power-on not recorded");

	// Serial, timer-2 and capture sources reach their own flag bits; the conversion flag holds
	a_serial_flag: assert property (@(posedge clk) disable iff (rst) // R1
		serial_done |=> flags[pifr_pkg::BIT_SERIAL])
		else $error("serial flag not set");
	a_match_flag: assert property (@(posedge clk) disable iff (rst) // R5
		timer2_match |=> flags[pifr_pkg::BIT_TIMER2])
		else $error("timer2 match flag not set");
	a_capture_flag: assert property (@(posedge clk) disable iff (rst) // R15
		(!ccp_compare_mode && capture_event) |=> flags[pifr_pkg::BIT_CCP])
		else $error("capture not flagged");
	a_conv_sticky: assert property (@(posedge clk) disable iff (rst) // R4
		(flags[pifr_pkg::BIT_CONV] && !(wr && hit(addr, pifr_pkg::ADDR_FLAGS)))
		|=> flags[pifr_pkg::BIT_CONV])
		else $error("conversion flag cleared by hardware");

	// Software writes land where no event competes
	a_flag_write: assert property (@(posedge clk) disable iff (rst) // R3
		(s_flag_write and (periph_set == pifr_pkg::ZERO_BYTE))
		|=> flags == ($past(wdata) & pifr_pkg::PERIPH_MASK))
		else $error("flag write lost");
	a_enable_write: assert property (@(posedge clk) disable iff (rst) // R6
		s_enable_write |=> enables == ($past(wdata) & pifr_pkg::PERIPH_MASK))
		else $error("enable write lost");
	a_gie_write: assert property (@(posedge clk) disable iff (rst) // R7
		s_ctrl_write |=> ctrl[pifr_pkg::BIT_GIE] == $past(wdata[pifr_pkg::BIT_GIE]))
		else $error("control write lost");
	a_cause_write: assert property (@(posedge clk) disable iff (rst) // R9
		s_cause_write |=> cause == $past(wdata[1:0]))
		else $error("cause write lost");

	// Control flags and cause bits follow their events
	a_t0_flag: assert property (@(posedge clk) disable iff (rst) // R7
		timer0_overflow |=> ctrl[pifr_pkg::BIT_T0F])
		else $error("timer0 flag not set");
	a_ext_flag: assert property (@(posedge clk) disable iff (rst) // R7
		ext_pin_event |=> ctrl[pifr_pkg::BIT_EXTF])
		else $error("pin flag not set");
	a_port_flag: assert property (@(posedge clk) disable iff (rst) // R7
		port_change_event |=> ctrl[pifr_pkg::BIT_PORTF])
		else $error("port change flag not set");
	a_bor_cause: assert property (@(posedge clk) disable iff (rst) // R10
		bor_seen |=> !cause[pifr_pkg::BIT_BROWNOUT])
		else $error("brown-out not recorded");
	a_bod_gate: assert property (@(posedge clk) disable iff (rst) // R11
		!bod_en_s |=> !bor_seen)
		else $error("brown-out seen while detection off");
	a_flags_read: assert property (@(posedge clk) disable iff (rst) // R3
		s_flags_read |=> rdata == $past(flags))
		else $error("flag read data wrong");

	// Request holds while the peripheral group stays pending
	sequence s_periph_pending;
		ctrl[pifr_pkg::BIT_GIE] && ctrl[pifr_pkg::BIT_PERIPHERAL_IRQ_ENABLE] && |(flags & enables);
	endsequence

	a_irq_follow: assert property (@(posedge clk) disable iff (rst) // R13
		s_periph_pending ##1 s_periph_pending |-> irq_request)
		else $error("request dropped while pending");
endmodule
